//--- eqbank_defines.vh
`ifndef EQBANK_DEFINES_VH
`define EQBANK_DEFINES_VH
// shared page offsets
`define OFS_INIT_CTRL      8'he2
`define OFS_REVISION       8'hf0
`define OFS_PART_ID        8'hf1
`define OFS_PAGE_CTRL      8'hff
// equalizer page offsets
`define OFS_EQ_CTRL        8'h00
// reset values
`define RST_INIT_CTRL      8'h10
`define RST_EQ_CTRL        8'h08
`define RST_PAGE_CTRL      8'h00
// reserved shared words at the bottom of the map
`define OFS_SHARED_RSVD_LAST 8'h09
`define OFS_SHARED_RW_FIRST  8'h02
`define OFS_SHARED_RW_LAST   8'h08
`define RST_SHARED_00      8'h00
`define RST_SHARED_01      8'h40
`define RST_SHARED_02      8'h02
`define RST_SHARED_03      8'h00
`define RST_SHARED_04      8'h01
`define RST_SHARED_05      8'h00
`define RST_SHARED_06      8'h00
`define RST_SHARED_07      8'h04
`define RST_SHARED_08      8'h11
`define RST_SHARED_09      8'h00
// arbitrary identity values
`define REVISION_CODE      8'h5a
`define PART_CODE_VALUE    8'ha5
// field positions
`define BIT_INIT_TRIGGER   0
`define BIT_INIT_DONE      4
`define BIT_PAGE_ENABLE    2
`define PAGE_EQ            2'h1
`define BIT_DETECT_SRC     7
`define BIT_LP_OVERRIDE    5
`define LP_MODE_HI         4
`define LP_MODE_LO         3
`define BIT_EQ_CLEAR       2
`define LP_AUTO            2'h0
`define LP_OFF             2'h1
`define LP_FORCE           2'h3
// init sequence length in cycles
`define INIT_CYCLES        16'h0040
`endif

//--- init_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "eqbank_defines.vh"
module init_sequencer #(
   parameter [15:0] INIT_LEN = `INIT_CYCLES
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       start,
   output reg        busy,
   output reg        done,
   output wire       load_pulse
);
   localparam S_IDLE = 1'b0;
   localparam S_RUN  = 1'b1;
   reg        state;
   reg [15:0] count;
   ////////////////////////////////////////////////////////////
   // counts through the default-load sequence
   always @(posedge clk)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         count <= 16'h0000;
         busy  <= 1'b0;
         done  <= 1'b1;
      end
      else
      begin
         case (state)
            S_IDLE:
            begin
               if (start)
               begin
                  state <= S_RUN;
                  count <= INIT_LEN - 16'h0001;
                  busy  <= 1'b1;
                  done  <= 1'b0;
               end
            end
            S_RUN:
            begin
               if (count == 16'h0000)
               begin
                  state <= S_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end
               else
                  count <= count - 16'h0001;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
   // defaults are loaded once, at the first cycle of the run
   assign load_pulse = (state == S_IDLE) && start;
endmodule // init_sequencer
`default_nettype wire

//--- low_power_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "eqbank_defines.vh"
module low_power_ctrl (
   input  wire       clk,
   input  wire       rst,
   input  wire       override,
   input  wire [1:0] mode,
   input  wire       carrier,
   output reg        power_save
);
   reg next_power_save;
   ////////////////////////////////////////////////////////////
   // mode decode; reserved code 10 treated like auto
   always @*
   begin
      next_power_save = ~carrier;
      if (override)
      begin
         case (mode)
            `LP_AUTO:  next_power_save = ~carrier;
            `LP_OFF:   next_power_save = 1'b0;
            `LP_FORCE: next_power_save = 1'b1;
            default:   next_power_save = ~carrier;
         endcase
      end
   end
   // registered so the output pin never glitches
   always @(posedge clk)
   begin
      if (rst)
         power_save <= 1'b1;
      else
         power_save <= next_power_save;
   end
endmodule // low_power_ctrl
`default_nettype wire

//--- paged_config_register_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "eqbank_defines.vh"
module paged_config_register_bank #(
   parameter [15:0] INIT_LEN = `INIT_CYCLES
) (
   input  wire       CORE_CLK,
   input  wire       RST,
   input  wire       WR_EN,
   input  wire       RD_EN,
   input  wire [7:0] ADDR,
   input  wire [7:0] WDATA,
   output reg  [7:0] RDATA,
   input  wire       CARRIER_PRESENT,
   input  wire       COARSE_ADAPT_DONE,
   output reg        CARRIER_FLAG_OUT_N,
   output wire       POWER_SAVE,
   output wire       INIT_BUSY
);
   reg  [7:0] page_ctrl;
   reg  [7:0] eq_ctrl;
   reg        init_trigger;
   reg  [2:0] init_rsvd;
   wire       init_done;
   wire       load_pulse;
   wire       shared_sel;
   wire       eq_sel;
   wire       init_wr;
   reg  [7:0] shared_rsvd [0:9];
   ////////////////////////////////////////////////////////////
   // page decode; shared page while enable bit is low
   assign shared_sel = ~page_ctrl[`BIT_PAGE_ENABLE];
   assign eq_sel     = page_ctrl[`BIT_PAGE_ENABLE] &&
                       (page_ctrl[1:0] == `PAGE_EQ);
   // one decode feeds both the init register and the sequencer start
   assign init_wr    = WR_EN && shared_sel && (ADDR == `OFS_INIT_CTRL);

   // page control lives on both pages so the host can always leave
   function is_page_reg;
      input [7:0] a;
      begin
         is_page_reg = (a == `OFS_PAGE_CTRL);
      end
   endfunction

   // reserved shared words sit at the bottom of the map
   function is_shared_rsvd;
      input [7:0] a;
      begin
         is_shared_rsvd = (a <= `OFS_SHARED_RSVD_LAST);
      end
   endfunction

   // only the middle reserved words take writes; the ends are read-only
   function is_shared_rsvd_rw;
      input [7:0] a;
      begin
         is_shared_rsvd_rw = (a >= `OFS_SHARED_RW_FIRST) &&
                             (a <= `OFS_SHARED_RW_LAST);
      end
   endfunction

   ////////////////////////////////////////////////////////////
   // page control register; starts on shared page
   always @(posedge CORE_CLK)
   begin
      if (RST)
         page_ctrl <= `RST_PAGE_CTRL;
      else if (WR_EN && is_page_reg(ADDR))
         page_ctrl <= WDATA;
   end

   ////////////////////////////////////////////////////////////
   // shared init register; trigger reads back as written
   always @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         init_trigger <= 1'b0;
         init_rsvd    <= 3'b000;
      end
      else if (init_wr)
      begin
         init_trigger <= WDATA[`BIT_INIT_TRIGGER];
         init_rsvd    <= WDATA[3:1];
      end
   end

   ////////////////////////////////////////////////////////////
   // reserved shared words; defaults in 02 to 08 stand until the host writes them, 00, 01 and 09 ignore writes,
   // so a read-modify-write by the host never disturbs them
   always @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         shared_rsvd[0] <= `RST_SHARED_00;
         shared_rsvd[1] <= `RST_SHARED_01;
         shared_rsvd[2] <= `RST_SHARED_02;
         shared_rsvd[3] <= `RST_SHARED_03;
         shared_rsvd[4] <= `RST_SHARED_04;
         shared_rsvd[5] <= `RST_SHARED_05;
         shared_rsvd[6] <= `RST_SHARED_06;
         shared_rsvd[7] <= `RST_SHARED_07;
         shared_rsvd[8] <= `RST_SHARED_08;
         shared_rsvd[9] <= `RST_SHARED_09;
      end
      else if (WR_EN && shared_sel && is_shared_rsvd_rw(ADDR))
         shared_rsvd[ADDR[3:0]] <= WDATA;
   end

   init_sequencer #(
      .INIT_LEN   (INIT_LEN)
   ) u_init (
      .clk        (CORE_CLK),
      .rst        (RST),
      .start      (init_wr && WDATA[`BIT_INIT_TRIGGER]),
      .busy       (INIT_BUSY),
      .done       (init_done),
      .load_pulse (load_pulse)
   );

   ////////////////////////////////////////////////////////////
   // equalizer control; clear bit never stored, so reads zero
   always @(posedge CORE_CLK)
   begin
      if (RST || load_pulse)
         eq_ctrl <= `RST_EQ_CTRL;
      else if (WR_EN && eq_sel && ADDR == `OFS_EQ_CTRL)
      begin
         if (WDATA[`BIT_EQ_CLEAR])
            eq_ctrl <= `RST_EQ_CTRL;
         else
            eq_ctrl <= WDATA;
      end
      // writes with an invalid page code fall through untouched
   end

   low_power_ctrl u_lp (
      .clk        (CORE_CLK),
      .rst        (RST),
      .override   (eq_ctrl[`BIT_LP_OVERRIDE]),
      .mode       (eq_ctrl[`LP_MODE_HI:`LP_MODE_LO]),
      .carrier    (CARRIER_PRESENT),
      .power_save (POWER_SAVE)
   );

   ////////////////////////////////////////////////////////////
   // detect pin source select, active low out
   always @(posedge CORE_CLK)
   begin
      if (RST)
         CARRIER_FLAG_OUT_N <= 1'b1;
      else if (eq_ctrl[`BIT_DETECT_SRC])
         CARRIER_FLAG_OUT_N <= ~CARRIER_PRESENT;
      else
         CARRIER_FLAG_OUT_N <= ~COARSE_ADAPT_DONE;
   end

   ////////////////////////////////////////////////////////////
   // registered read data, one cycle after RD_EN
   always @(posedge CORE_CLK)
   begin
      if (RST)
         RDATA <= 8'h00;
      else if (RD_EN)
      begin
         if (is_page_reg(ADDR))
            RDATA <= page_ctrl;
         else if (shared_sel)
         begin
            case (ADDR)
               `OFS_INIT_CTRL:
                  RDATA <= {3'b000, init_done, init_rsvd, init_trigger};
               `OFS_REVISION: RDATA <= `REVISION_CODE;
               `OFS_PART_ID:  RDATA <= `PART_CODE_VALUE;
               default:
               begin
                  if (is_shared_rsvd(ADDR))
                     RDATA <= shared_rsvd[ADDR[3:0]];
                  else
                     RDATA <= 8'h00;
               end
            endcase
         end
         else if (eq_sel && ADDR == `OFS_EQ_CTRL)
            RDATA <= eq_ctrl & 8'hfb;
         else
            RDATA <= 8'h00;
      end
   end
endmodule // paged_config_register_bank
`default_nettype wire

//--- eqbank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eqbank_asserts (
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic       WR_EN,
   input wire logic       RD_EN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] RDATA,
   input wire logic       CARRIER_PRESENT,
   input wire logic       COARSE_ADAPT_DONE,
   input wire logic       CARRIER_FLAG_OUT_N,
   input wire logic       POWER_SAVE,
   input wire logic       INIT_BUSY
);
   logic [2:0] pg;
   logic [7:0] eq;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of page select and eq control; clear write or init restores default
   always @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         pg <= 3'h0;
         eq <= 8'h08;
      end
      else if (WR_EN && ADDR == 8'hff)
         pg <= WDATA[2:0];
      else if (WR_EN && ADDR == 8'h00 && pg == 3'h5)
         eq <= WDATA[2] ? 8'h08 : WDATA;
      else if (WR_EN && ADDR == 8'he2 && !pg[2] && WDATA[0] && !INIT_BUSY)
         eq <= 8'h08;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // bus-visible relations
   property p_init; WR_EN && ADDR == 8'he2 && WDATA[0] && !pg[2] |=> INIT_BUSY; endproperty
   a_init: assert property (p_init) else $error("init idle");
   property p_done; RD_EN && ADDR == 8'he2 && !pg[2] |=> RDATA[4] == !$past(INIT_BUSY); endproperty
   a_done: assert property (p_done) else $error("done flag");
   property p_id; RD_EN && ADDR == 8'hf1 && !pg[2] |=> RDATA == 8'ha5; endproperty
   a_id: assert property (p_id) else $error("id code");
   property p_eqrd; RD_EN && ADDR == 8'h00 && pg == 3'h5 |=> RDATA == eq; endproperty
   a_eqrd: assert property (p_eqrd) else $error("eq page read");
   property p_bad; RD_EN && pg[2] && pg[1:0] != 2'b01 && ADDR != 8'hff |=> RDATA == 8'h00; endproperty
   a_bad: assert property (p_bad) else $error("bad page read");
   // pin and power outputs are registered one cycle behind their cause
   property p_pin; eq[7] |=> CARRIER_FLAG_OUT_N == !$past(CARRIER_PRESENT); endproperty
   a_pin: assert property (p_pin) else $error("detect pin");
   property p_auto; !eq[5] |=> POWER_SAVE == !$past(CARRIER_PRESENT); endproperty
   a_auto: assert property (p_auto) else $error("auto save");
   property p_force; eq[5:3] == 3'b111 |=> POWER_SAVE; endproperty
   a_force: assert property (p_force) else $error("forced save");
   property p_adapt; !eq[7] |=> CARRIER_FLAG_OUT_N == !$past(COARSE_ADAPT_DONE); endproperty
   a_adapt: assert property (p_adapt) else $error("adapt pin");
   property p_off; eq[5:3] == 3'b101 |=> !POWER_SAVE; endproperty
   a_off: assert property (p_off) else $error("save disabled");
   property p_rsvd; RD_EN && ADDR == 8'h01 && !pg[2] |=> RDATA == 8'h40; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved default");
endmodule // eqbank_asserts
`default_nettype wire

//--- host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output var  logic       we,
   output var  logic       re,
   output var  logic [7:0] a,
   output var  logic [7:0] d,
   input  wire logic [7:0] q
);
   // idle bus starts at zero, then carries the inverted address and data with we and re held low
   initial {we, re, a, d} = 18'h0;
   task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] dat,
                       output logic [7:0] r);
      @(posedge clk);
      we <= w;
      re <= !w;
      a  <= ad;
      d  <= dat;
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b0;
      a  <= ~ad;
      d  <= ~dat;
      #1 r = q;
   endtask
endmodule // host_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eqbank_defines.vh"
module tb;
   logic       CORE_CLK, RST = 1'b1, cp = 1'b0, cad = 1'b0, we, re, fl_n, ps, busy;
   logic [7:0] a, d, q;
   logic [3:0] m;
   int         err_count = 0, checked = 0, cyc = 0;
   host_model host (.clk(CORE_CLK), .we(we), .re(re), .a(a), .d(d), .q(q));
   paged_config_register_bank #(.INIT_LEN(16'd4)) uut (.CORE_CLK(CORE_CLK), .RST(RST),
      .WR_EN(we), .RD_EN(re), .ADDR(a), .WDATA(d), .RDATA(q), .CARRIER_PRESENT(cp),
      .COARSE_ADAPT_DONE(cad), .CARRIER_FLAG_OUT_N(fl_n), .POWER_SAVE(ps), .INIT_BUSY(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] ad, input logic [7:0] dat);
      logic [7:0] r;
      host.xfer(1'b1, ad, dat, r);
   endtask
   task rd(input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] r;
      host.xfer(1'b0, ad, 8'h00, r);
      chk(r, exp);
   endtask
   // bounded poll; the limit turns a stuck sequencer into a mismatch
   task wait_init;
      for (int i = 0; i < 50 && busy !== 1'b0; i++)
         #10;
      chk({7'h0, busy}, 8'h00);
   endtask
   // inputs change at an edge, outputs looked at after three edges
   task io(input logic c, input logic ad, input logic en, input logic eps);
      @(posedge CORE_CLK);
      cp  <= c;
      cad <= ad;
      repeat (3) @(posedge CORE_CLK);
      #1 chk({6'h0, fl_n, ps}, {6'h0, en, eps});
   endtask
   task final_report;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         final_report;
      end
   end
   initial
   begin
      repeat (3) @(posedge CORE_CLK);
      RST <= 1'b0;
      rd(8'hff, 8'h00);
      rd(8'he2, `RST_INIT_CTRL);
      rd(8'hf0, `REVISION_CODE);
      wr(8'hf1, 8'h00);
      rd(8'hf1, `PART_CODE_VALUE);
      wr(8'he2, 8'h01);
      rd(8'he2, 8'h01);
      wait_init;
      rd(8'he2, 8'h11);
      wr(8'hff, 8'h05);
      rd(8'h00, 8'h08);
      wr(8'h02, 8'h77);
      wr(8'h00, 8'h80);
      io(1'b1, 1'b0, 1'b0, 1'b0);
      io(1'b0, 1'b1, 1'b1, 1'b1);
      wr(8'h00, 8'h00);
      io(1'b0, 1'b1, 1'b0, 1'b1);
      // every override mode, with and without a carrier
      for (m = 4'h0; m < 4'h8; m++)
      begin
         wr(8'h00, {2'b00, 1'b1, m[1:0], 3'b000});
         io(m[2], 1'b0, 1'b1, (m[1:0] == 2'b11) | (!m[2] && m[1:0] != 2'b01));
      end
      wr(8'h00, 8'ha4);
      rd(8'h00, 8'h08);
      wr(8'hff, 8'h00);
      rd(8'h02, 8'h02);
      wr(8'he2, 8'h01);
      wait_init;
      wr(8'hff, 8'h06);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'h00);
      rd(8'hff, 8'h06);
      wr(8'hff, 8'h05);
      rd(8'h00, 8'h08);
      wr(8'hff, 8'h00);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h40);
      wr(8'h01, 8'hff);
      rd(8'h01, 8'h40);
      rd(8'h08, 8'h11);
      wr(8'h03, 8'h3c);
      rd(8'h03, 8'h3c);
      rd(8'h50, 8'h00);
      // second reset in mid-run, with the equalizer page selected
      wr(8'hff, 8'h05);
      @(posedge CORE_CLK) RST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 1'b0;
      rd(8'hff, 8'h00);
      rd(8'h03, 8'h00);
      final_report;
   end
endmodule // tb
bind paged_config_register_bank eqbank_asserts chk (.CORE_CLK(CORE_CLK), .RST(RST),
   .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
   .CARRIER_PRESENT(CARRIER_PRESENT), .COARSE_ADAPT_DONE(COARSE_ADAPT_DONE),
   .CARRIER_FLAG_OUT_N(CARRIER_FLAG_OUT_N), .POWER_SAVE(POWER_SAVE), .INIT_BUSY(INIT_BUSY));
`default_nettype wire
